// ### core/irs_top.sv
// Interrupt routing: cascaded legacy controllers, APIC mapping and serial IRQ receiver.
`timescale 1ns/1ps
// Summary of operation
// - Secondary levels 8-15 cascade onto primary level 2.
// - One combined output, one acknowledge per interrupt.
// - Programmable table maps sources onto APIC inputs.
// - APIC logic watches PCI and sixteen legacy inputs.
// - Asserted input sends identifying serial APIC message.
// - APIC bus: clock plus two bidirectional data lines.
// - More than sixteen APIC levels are deliverable.
// - Clock interrupt is active low, on level 8.
// - System management interrupt driven to processors.
// - Cycle: start frame, 17+ slots, stop frame.
// - Continuous mode: host issues every start frame.
// - Up to 32 channels, 17 by default.
// - Serial ports take levels 3 and 4, swappable.
module irs_top #(
    parameter int SER_CHANS = irs_pkg::SER_MIN // Serial channels per cycle, 17 to 32.
) (
    input wire logic clk_sys_i, // System clock, 25 MHz.
    input wire logic srst_i, // Synchronous reset, active high.
    input wire logic ce_i, // Clock enable; all state holds while low.
    input wire logic [15:0] irq_i, // Legacy level requests, active high.
    input wire logic rtc_irq_low_i, // Clock interrupt, active low.
    input wire logic [1:0] uart_irq_i, // Serial port requests.
    input wire logic uart_swap_i, // Swaps the two serial port levels.
    input wire logic [irs_pkg::PCI_INPUTS-1:0] pci_irq_n_i, // PCI interrupt pins, active low.
    input wire logic smi_req_i, // Management interrupt request.
    input wire logic inta_i, // Processor acknowledge pulse.
    input wire logic map_wr_i, // Mapping table write strobe.
    input wire logic [4:0] map_idx_i, // Mapping entry to write.
    input wire logic [irs_pkg::POOL_W-1:0] map_src_i, // Source index to store.
    input wire logic cont_mode_i, // High for continuous serial mode.
    input wire logic serial_irq_line_i, // Serial interrupt line level.
    output logic serial_irq_line_o, // Serial interrupt line drive value.
    output logic serial_irq_line_oe_o, // Serial line output enable.
    input wire logic apic_clk_i, // APIC bus clock.
    input wire logic [1:0] apic_d_i, // APIC data lines level.
    output logic [1:0] apic_d_o, // APIC data lines drive value.
    output logic apic_d_oe_o, // APIC data output enable.
    output logic intr_o, // Combined legacy interrupt.
    output logic [7:0] vector_o, // Vector taken by the last acknowledge.
    output logic smi_o, // Management interrupt to processors.
    output logic [irs_pkg::SER_MAX-1:0] ser_req_o // Held serial channel requests.
);
    localparam int SER_MAX_W = irs_pkg::SER_MAX;
    localparam int NSYNC = 16 + 1 + 2 + irs_pkg::PCI_INPUTS + 1 + 1 + 1 + 2;
    // Idle level of every synchronised pin, so that reset creates no false edge.
    localparam logic [NSYNC-1:0] SYNC_IDLE = {16'h0000, 1'b1, 2'h0, {irs_pkg::PCI_INPUTS{1'b1}}, 1'b0, 1'b1,
        1'b0, 2'h3};

    // Two-flop synchronisers for every pin from outside the clock domain.
    logic [NSYNC-1:0] s1_r, s2_r;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s1_r <= SYNC_IDLE;
            s2_r <= SYNC_IDLE;
        end else if (ce_i) begin
            s1_r <= {irq_i, rtc_irq_low_i, uart_irq_i, pci_irq_n_i, smi_req_i, serial_irq_line_i, apic_clk_i, apic_d_i};
            s2_r <= s1_r;
        end
    end
    logic [15:0] irq_s;
    logic rtc_s, smi_s, ser_s, aclk_s;
    logic [1:0] uart_s;
    logic [irs_pkg::PCI_INPUTS-1:0] pci_n_s;
    assign {irq_s, rtc_s, uart_s, pci_n_s, smi_s, ser_s, aclk_s} = s2_r[NSYNC-1:2];

    // Legacy levels, with the clock and serial port levels fixed in place.
    logic [15:0] lvl_w, lvl_d_r, rise_w, pend_r;
    logic [SER_MAX_W-1:0] ser_req_r;
    always_comb begin
        lvl_w = irq_s | ser_req_r[15:0];
        lvl_w[irs_pkg::RTC_LVL] = ~rtc_s;
        lvl_w[irs_pkg::UART_LVL_A] = uart_swap_i ? uart_s[1] : uart_s[0];
        lvl_w[irs_pkg::UART_LVL_B] = uart_swap_i ? uart_s[0] : uart_s[1];
    end
    assign rise_w = lvl_w & ~lvl_d_r;

    // Highest priority pending level through the cascade.
    logic [7:0] prim_w;
    logic [3:0] pick_w;
    logic pick_ok_w;
    always_comb begin
        prim_w = pend_r[7:0];
        prim_w[irs_pkg::CASCADE_LVL] = |pend_r[15:8];
        pick_w = 4'h0;
        pick_ok_w = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (prim_w[i]) begin
                pick_w = 4'(i);
                pick_ok_w = 1'b1;
            end
        end
        if (pick_ok_w && pick_w == 4'(irs_pkg::CASCADE_LVL)) begin
            for (int j = 15; j >= 8; j--) begin
                if (pend_r[j]) begin
                    pick_w = 4'(j);
                end
            end
        end
    end

    // Pending edges; a new edge wins over the clear by acknowledge.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            lvl_d_r <= 16'h0000;
            pend_r <= 16'h0000;
            intr_o <= 1'b0;
            vector_o <= 8'h00;
        end else if (ce_i) begin
            lvl_d_r <= lvl_w;
            pend_r <= (pend_r & ~((inta_i && pick_ok_w) ? (16'h0001 << pick_w) : 16'h0000)) | rise_w;
            intr_o <= |pend_r;
            if (inta_i && pick_ok_w) begin
                vector_o <= {irs_pkg::PIC_VEC_HI, pick_w};
            end
        end
    end
    cascade_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (ce_i && inta_i && pend_r[15:8] != 8'h00 && pend_r[1:0] == 2'h0) |=> vector_o[3])
        else $error("cascade level not served through level two");
    intr_out_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i |=> intr_o == $past(|pend_r))
        else $error("combined interrupt does not follow pending levels");
    rtc_low_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (ce_i && $past(ce_i) && $fell(rtc_s)) |=> pend_r[irs_pkg::RTC_LVL])
        else $error("falling clock interrupt not pending on level eight");

    // Management interrupt output.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            smi_o <= 1'b0;
        end else if (ce_i) begin
            smi_o <= smi_s;
        end
    end
    smi_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i |=> smi_o == $past(smi_s))
        else $error("management interrupt not forwarded");

    // Source pool for mapping: legacy, serial channels, PCI pins.
    logic [63:0] pool_w;
    assign pool_w = {~pci_n_s, ser_req_r, lvl_w};

    // Mapping table, one entry per APIC input, written through the map port.
    logic [irs_pkg::POOL_W-1:0] map_r [irs_pkg::APIC_PINS];
    logic [irs_pkg::APIC_PINS-1:0] pin_w, pin_d_r, apend_r, aclr_w;
    for (genvar p = 0; p < irs_pkg::APIC_PINS; p++) begin : g_map
        localparam logic [irs_pkg::POOL_W-1:0] MAP_RST = (p < 16) ? 6'(p) : 6'(irs_pkg::PCI_BASE + p - 16);
        always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
                map_r[p] <= MAP_RST;
            end else if (ce_i && map_wr_i && map_idx_i == 5'(p)) begin
                map_r[p] <= map_src_i;
            end
        end
        assign pin_w[p] = pool_w[map_r[p]];
    end
    map_wr_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (ce_i && map_wr_i && map_idx_i < 5'(irs_pkg::APIC_PINS)) |=> map_r[$past(map_idx_i)] == $past(map_src_i))
        else $error("mapping write not stored");

    // APIC clock edge from the synchronised clock.
    logic aclk_d_r, arise_w;
    assign arise_w = ce_i && aclk_s && !aclk_d_r;

    // Lowest pending APIC input is sent next.
    logic [4:0] apick_w;
    always_comb begin
        apick_w = 5'h00;
        for (int k = irs_pkg::APIC_PINS - 1; k >= 0; k--) begin
            if (apend_r[k]) begin
                apick_w = 5'(k);
            end
        end
    end

    typedef enum logic [1:0] {T_IDLE = 2'b01, T_SEND = 2'b10} irs_tx_t;
    irs_tx_t tx_r;
    logic [irs_pkg::MSG_BITS-1:0] sh_r;
    logic [2:0] beat_r;
    logic [7:0] avec_w;
    assign avec_w = {irs_pkg::APIC_VEC_HI, apick_w};
    assign aclr_w = (arise_w && tx_r == T_IDLE && |apend_r) ? (24'h000001 << apick_w) : 24'h000000;

    // Serial message sender: two bits per APIC clock, pending set wins.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            aclk_d_r <= 1'b0;
            pin_d_r <= '0;
            apend_r <= '0;
            tx_r <= T_IDLE;
            sh_r <= '0;
            beat_r <= 3'h0;
        end else if (ce_i) begin
            aclk_d_r <= aclk_s;
            pin_d_r <= pin_w;
            apend_r <= (apend_r & ~aclr_w) | (pin_w & ~pin_d_r);
            if (arise_w) begin
                unique case (tx_r)
                    T_IDLE: begin
                        if (|apend_r) begin
                            sh_r <= {irs_pkg::MSG_HDR, avec_w, ^avec_w[7:4], ^avec_w[3:0]};
                            beat_r <= 3'h0;
                            tx_r <= T_SEND;
                        end
                    end
                    T_SEND: begin
                        sh_r <= {sh_r[irs_pkg::MSG_BITS-3:0], 2'h0};
                        beat_r <= beat_r + 3'h1;
                        if (beat_r == irs_pkg::MSG_BEATS - 3'h1) begin
                            tx_r <= T_IDLE;
                        end
                    end
                endcase
            end
        end
    end
    assign apic_d_o = sh_r[irs_pkg::MSG_BITS-1:irs_pkg::MSG_BITS-2];
    assign apic_d_oe_o = (tx_r == T_SEND);
    apic_msg_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (arise_w && tx_r == T_IDLE && |apend_r) |=> (apic_d_oe_o && apic_d_o == irs_pkg::MSG_HDR))
        else $error("pending input did not start a message");

    // Serial interrupt receiver and frame generator.
    typedef enum logic [3:0] {S_IDLE = 4'b0001, S_START = 4'b0010, S_SLOT = 4'b0100, S_STOP = 4'b1000} irs_ser_t;
    irs_ser_t st_r;
    logic [3:0] cnt_r;
    logic [4:0] slot_r;
    logic [SER_MAX_W-1:0] shadow_r;
    logic samp_w, upd_w;
    assign samp_w = ce_i && st_r == S_SLOT && cnt_r == irs_pkg::SAMPLE_AT;
    assign upd_w = ce_i && st_r == S_STOP && cnt_r == irs_pkg::STOP_CYC - 4'h1;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st_r <= S_IDLE;
            cnt_r <= 4'h0;
            slot_r <= 5'h00;
            shadow_r <= '0;
            ser_req_r <= '0;
        end else if (ce_i) begin
            cnt_r <= cnt_r + 4'h1;
            unique case (st_r)
                S_IDLE: begin
                    // Count two idle cycles so that the echo of our own stop frame is not taken as a start.
                    if (cnt_r < 4'h2) begin
                        cnt_r <= cnt_r + 4'h1;
                    end else begin
                        cnt_r <= cnt_r;
                    end
                    if (cont_mode_i || (!ser_s && cnt_r == 4'h2)) begin
                        st_r <= S_START;
                        cnt_r <= 4'h0;
                    end
                end
                S_START: begin
                    if (cnt_r == irs_pkg::START_CYC - 4'h1) begin
                        st_r <= S_SLOT;
                        cnt_r <= 4'h0;
                        slot_r <= 5'h00;
                    end
                end
                S_SLOT: begin
                    if (samp_w) begin
                        shadow_r[slot_r] <= ~ser_s;
                    end
                    if (cnt_r == irs_pkg::SLOT_CYC - 4'h1) begin
                        cnt_r <= 4'h0;
                        slot_r <= slot_r + 5'h01;
                        if (slot_r == 5'(SER_CHANS - 1)) begin
                            st_r <= S_STOP;
                        end
                    end
                end
                S_STOP: begin
                    if (upd_w) begin
                        ser_req_r <= shadow_r;
                        st_r <= S_IDLE;
                        cnt_r <= 4'h0;
                    end
                end
            endcase
        end
    end
    assign serial_irq_line_o = 1'b0;
    assign serial_irq_line_oe_o = (st_r == S_START) || (st_r == S_STOP);
    assign ser_req_o = ser_req_r;
    cont_start_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (ce_i && st_r == S_IDLE && cont_mode_i) |=> (st_r == S_START && serial_irq_line_oe_o))
        else $error("continuous mode did not issue a start frame");
    slot_count_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (st_r == S_STOP && $past(st_r) == S_SLOT) |-> $past(slot_r) == 5'(SER_CHANS - 1))
        else $error("cycle ended after wrong slot count");
    slot_latch_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (samp_w && !ser_s) |=> shadow_r[$past(slot_r)])
        else $error("low slot not latched for its channel");
    req_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !upd_w |=> $stable(ser_req_r))
        else $error("held requests changed outside stop frame");
endmodule : irs_top

// ### inc/irs_pkg.sv
// Shared constants for the interrupt routing and serial interrupt block.
package irs_pkg;
    localparam int LEG_LEVELS = 16; // Legacy interrupt levels.
    localparam int SER_MAX = 32; // Largest serial channel count per cycle.
    localparam int SER_MIN = 17; // Smallest serial channel count per cycle.
    localparam int PCI_INPUTS = 16; // PCI interrupt pins watched.
    localparam int POOL_W = 6; // Width of a mapping source index.
    localparam int APIC_PINS = 24; // Redirection inputs of the I/O APIC.
    localparam int CASCADE_LVL = 2; // Primary level fed by the secondary.
    localparam int RTC_LVL = 8; // Level of the active-low clock interrupt.
    localparam int UART_LVL_A = 3; // First serial port level.
    localparam int UART_LVL_B = 4; // Second serial port level.
    localparam int SER_BASE = 16; // Pool index of serial channel 0.
    localparam int PCI_BASE = 48; // Pool index of PCI pin 0.
    localparam logic [3:0] PIC_VEC_HI = 4'h2; // Upper nibble of legacy vectors.
    localparam logic [2:0] APIC_VEC_HI = 3'h1; // Upper bits of APIC vectors.
    localparam logic [1:0] MSG_HDR = 2'h1; // Header beat of an APIC message.
    localparam int MSG_BITS = 12; // Header, vector and check bits.
    localparam logic [2:0] MSG_BEATS = 3'h6; // Two bits per APIC clock.
    localparam logic [3:0] START_CYC = 4'h8; // Start frame length in clocks.
    localparam logic [3:0] STOP_CYC = 4'h4; // Stop frame length in clocks.
    localparam logic [3:0] SLOT_CYC = 4'h6; // One channel slot in clocks.
    localparam logic [3:0] SAMPLE_AT = 4'h3; // Sample clock inside a slot, two later for the synchroniser.
endpackage : irs_pkg

// ### tb/irs_far_model.sv
// Far side: serial interrupt slaves on a pulled-up line, and an APIC bus listener.
`timescale 1ns/1ps
module irs_far_model (
    input wire logic clk_sys_i, // System clock.
    input wire logic srst_i, // Reset, active high.
    input wire logic line_drv_i, // Device drive value.
    input wire logic line_oe_i, // Device drive enable.
    input wire logic [31:0] chan_req_i, // Channels whose slave wants service.
    input wire logic kick_i, // A slave asks to start a cycle.
    output logic line_o, // Line level seen by all.
    input wire logic apic_clk_i, // APIC clock.
    input wire logic [1:0] apic_drv_i, // Device data drive.
    input wire logic apic_oe_i, // Device data enable.
    output logic [1:0] apic_o, // Data level seen by all.
    output logic [11:0] msg_o, // Last message heard.
    output logic [7:0] msg_cnt_o // Messages heard.
);
    logic in_frame; // High from the start frame to the stop frame.
    logic oe_q; // Enable one cycle back.
    logic [7:0] pos; // Cycles since the start frame ended.
    logic [2:0] beats; // Beats of the current message.
    logic pull_low; // Some slave pulls the line low.
    // A slave holds its slot low for three cycles; an idle line may be pulled low to start a cycle.
    assign pull_low = (in_frame && !line_oe_i && pos < 8'hC0 && chan_req_i[pos / 8'h06]
        && pos % 8'h06 < 8'h03) || (kick_i && !in_frame && !line_oe_i);
    // Released lines float back to their pull-ups, so no stale value lingers.
    assign line_o = !((line_oe_i && !line_drv_i) || pull_low);
    assign apic_o = apic_oe_i ? apic_drv_i : 2'h3;
    // Frame tracking: each rising enable toggles between start and stop frames.
    always @(posedge clk_sys_i) begin
        oe_q <= srst_i ? 1'b0 : line_oe_i;
        if (srst_i) begin
            in_frame <= 1'b0;
        end else if (line_oe_i && !oe_q) begin
            in_frame <= !in_frame;
        end
        pos <= (srst_i || line_oe_i) ? 8'h00 : pos + 8'h01;
    end
    // Each beat stands until the next rise, so it is taken at the rise after it was put out.
    always @(posedge apic_clk_i) begin
        if (srst_i) begin
            beats <= 3'h0;
            msg_cnt_o <= 8'h00;
        end else if (apic_oe_i) begin
            msg_o <= {msg_o[9:0], apic_o};
            beats <= (beats == 3'h5) ? 3'h0 : beats + 3'h1;
            msg_cnt_o <= msg_cnt_o + ((beats == 3'h5) ? 8'h01 : 8'h00);
        end else begin
            beats <= 3'h0;
        end
    end
endmodule : irs_far_model

// ### tb/irs_top_tb.sv
// Self-checking bench for the interrupt routing and serial interrupt block.
`timescale 1ns/1ps
module irs_top_tb;
    logic clk_sys_i = 1'b0, srst_i = 1'b1, rtc_irq_low_i = 1'b1, uart_swap_i = 1'b1, smi_req_i = 1'b0;
    logic inta_i = 1'b0, map_wr_i = 1'b0, cont_mode_i = 1'b0, apic_clk_i = 1'b0, kick = 1'b0, ce = 1'b1;
    logic [15:0] irq_i = 16'h0000, pci_irq_n_i = 16'hFFFF; // Requests at rest.
    logic [1:0] uart_irq_i = 2'h0, apic_w, apic_drv; // Serial ports and APIC data.
    logic [4:0] map_idx_i = 5'h00; // Map entry.
    logic [5:0] map_src_i = 6'h00; // Map source.
    logic line_w, line_drv, line_oe, intr_o, smi_o, apic_oe; // Line and outputs.
    logic [7:0] vector_o, msg_cnt; // Vector and message count.
    logic [11:0] msg; // Last APIC message.
    logic [31:0] ser_req_o, chan_req = 32'h0; // Held and requested channels.
    int fail_count = 0, n_checks = 0, cycles = 0; // Tallies.
    irs_top #(.SER_CHANS(irs_pkg::SER_MIN)) dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce),
        .irq_i(irq_i), .rtc_irq_low_i(rtc_irq_low_i), .uart_irq_i(uart_irq_i), .uart_swap_i(uart_swap_i),
        .pci_irq_n_i(pci_irq_n_i), .smi_req_i(smi_req_i), .inta_i(inta_i), .map_wr_i(map_wr_i),
        .map_idx_i(map_idx_i), .map_src_i(map_src_i), .cont_mode_i(cont_mode_i), .serial_irq_line_i(line_w),
        .serial_irq_line_o(line_drv), .serial_irq_line_oe_o(line_oe), .apic_clk_i(apic_clk_i), .apic_d_i(apic_w),
        .apic_d_o(apic_drv), .apic_d_oe_o(apic_oe), .intr_o(intr_o), .vector_o(vector_o), .smi_o(smi_o),
        .ser_req_o(ser_req_o));
    irs_far_model far (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .line_drv_i(line_drv), .line_oe_i(line_oe),
        .chan_req_i(chan_req), .kick_i(kick), .line_o(line_w), .apic_clk_i(apic_clk_i), .apic_drv_i(apic_drv),
        .apic_oe_i(apic_oe), .apic_o(apic_w), .msg_o(msg), .msg_cnt_o(msg_cnt));
    // System clock at 25 MHz; APIC clock at 320 ns with an unrelated phase.
    always #20 clk_sys_i = !clk_sys_i;
    initial begin
        #7;
        forever #160 apic_clk_i = !apic_clk_i;
    end
    // Compares and tallies one value.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    // Prints the tallies and the verdict, then stops.
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    // One acknowledge pulse; the vector lands one edge after it is taken.
    task automatic ack(input logic [7:0] exp);
        @(posedge clk_sys_i) inta_i <= 1'b1;
        @(posedge clk_sys_i) inta_i <= 1'b0;
        @(posedge clk_sys_i);
        @(negedge clk_sys_i) chk(32'(vector_o), 32'(exp));
    endtask : ack
    // Waits for the next complete APIC message and checks header, vector and check bits.
    task automatic wait_msg(input logic [7:0] v);
        logic [7:0] c;
        int n;
        c = msg_cnt;
        n = 0;
        while (msg_cnt === c && n < 600) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk(32'(msg), 32'({2'h1, v, ^v[7:4], ^v[3:0]}));
    endtask : wait_msg
    // Four levels at once: priority order, cascade, clock polarity, port swap, refused acknowledge.
    task automatic t_legacy();
        @(posedge clk_sys_i) begin
            irq_i <= 16'h0220;
            rtc_irq_low_i <= 1'b0;
            uart_irq_i <= 2'h1;
        end
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i) chk(32'(intr_o), 32'h1);
        ack(8'h28);
        ack(8'h29);
        ack(8'h24);
        ack(8'h25);
        ack(8'h25);
        chk(32'(intr_o), 32'h0);
        wait_msg(8'h24);
        wait_msg(8'h25);
        wait_msg(8'h28);
        wait_msg(8'h29);
        @(posedge clk_sys_i) pci_irq_n_i <= 16'hFFF7;
        wait_msg(8'h33);
        $display("test legacy and apic done");
    endtask : t_legacy
    // Management request passes through, but not while the clock enable is low.
    task automatic t_smi();
        @(posedge clk_sys_i) begin
            smi_req_i <= 1'b1;
            ce <= 1'b0;
        end
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i) chk(32'(smi_o), 32'h0);
        @(posedge clk_sys_i) ce <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i) chk(32'(smi_o), 32'h1);
        @(posedge clk_sys_i) smi_req_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i) chk(32'(smi_o), 32'h0);
        $display("test smi done");
    endtask : t_smi
    // Continuous serial cycles, second and last channel, remapped APIC pin above sixteen.
    task automatic t_cont();
        int n;
        @(posedge clk_sys_i) begin
            map_wr_i <= 1'b1;
            map_idx_i <= 5'h14;
            map_src_i <= 6'h11;
        end
        @(posedge clk_sys_i) begin
            map_wr_i <= 1'b0;
            chan_req <= 32'h0001_0002;
            cont_mode_i <= 1'b1;
        end
        n = 0;
        while (line_oe !== 1'b1 && n < 50) begin
            @(negedge clk_sys_i);
            n++;
        end
        n = 0;
        while (line_oe === 1'b1 && n < 50) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk(32'(n), 32'h8);
        wait_msg(8'h21);
        wait_msg(8'h34);
        chk(ser_req_o, 32'h0001_0002);
        @(posedge clk_sys_i) chan_req <= 32'h0;
        repeat (240) @(posedge clk_sys_i);
        @(negedge clk_sys_i) chk(ser_req_o, 32'h0);
        $display("test continuous done");
    endtask : t_cont
    // Quiet mode: no cycle until a slave pulls the line low.
    task automatic t_quiet();
        int n;
        @(posedge clk_sys_i) cont_mode_i <= 1'b0;
        repeat (240) @(posedge clk_sys_i);
        @(negedge clk_sys_i) chk({ser_req_o[30:0], line_oe}, 32'h0);
        @(posedge clk_sys_i) begin
            kick <= 1'b1;
            chan_req <= 32'h20;
        end
        n = 0;
        while (line_oe !== 1'b1 && n < 50) begin
            @(negedge clk_sys_i);
            n++;
        end
        @(posedge clk_sys_i) kick <= 1'b0;
        repeat (240) @(posedge clk_sys_i);
        @(negedge clk_sys_i) chk(ser_req_o, 32'h20);
        $display("test quiet done");
    endtask : t_quiet
    // Cuts a hang short.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(negedge clk_sys_i) chk({intr_o, smi_o, line_oe, apic_oe, vector_o, ser_req_o[19:0]}, 32'h0);
        t_legacy();
        t_smi();
        t_cont();
        t_quiet();
        conclude();
    end
endmodule : irs_top_tb
